// File: design/dsf_dev_end.sv
// Transceiver end: config and queue SPI slaves, queue, serializer.
// Assumes a host master on the pins and a modem on the user side.
//
// Contract
// - Pin directions follow chip state, path and lock enable
// - Interrupt lines float in sleep, continuous idle
// - Lock pin driven only when enabled, awake
// - Serial output driven while any select low
// - Path select: 00 stream, 01 buffered, 1x packet
// - Stream mode bits pass on data pin
// - Buffered mode bytes go through the queue
// - Packet mode adds and strips framing
// - Packet payload capped at 64 bytes
// - Queue port only in buffered, packet modes
// - Two slaves share clock and data lines
// - Config select wins over queue select
// - Register writes apply at config deselect
// - Write bytes alternate address, value
// - Read bytes alternate address, value
// - Queue write pushes at deselect
// - Host reads one queue byte per select
// - Byte-wide queue, serializer joins modem
// - Transmit MSB first, one bit per period
// - Receive gathers bits into queue bytes
// - Queue depth 16, 32, 48 or 64
// - Not-empty flag frozen from queue select fall
// - Full-queue write lost, sets overrun, clear
`timescale 1ns/1ps
module dsf_dev_end #(
  parameter int QMAX = dsf_pkg::QUEUE_MAX
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_demod_bit,
  input wire logic i_pll_locked,
  output logic o_mod_bit,
  output dsf_pkg::dsf_chip_t o_chip_state,
  dsf_if.dev bus
);
  import dsf_pkg::*;
  localparam int AW = $clog2(QMAX);

  // ----------------------------------------------------------------
  // Link side, clocked by the host serial clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bitn;
    logic [6:0] sh;
    logic val;
    logic rd;
    logic [2:0] addr;
  } dsf_frm_t;
  typedef struct packed {
    logic tog;
    logic [7:0] data;
    logic cfg;
    logic val;
    logic rd;
  } dsf_pst_t;

  dsf_frm_t f, next_f;
  dsf_pst_t p, next_p;
  logic [2:0] ncnt;
  logic ophase;
  logic sel_none;
  logic frame_rstn;
  logic cfg_sel;
  logic [7:0] rd_word;
  logic [7:0] byte_w;

  // The clock stops between frames, so per-frame state is cleared by
  // the deselect itself; only the handoff register survives it.
  assign sel_none = bus.cfg_port_select_n & bus.queue_port_select_n;
  assign frame_rstn = i_rstn & ~sel_none;
  assign cfg_sel = ~bus.cfg_port_select_n;

  always_comb begin
    next_f = f;
    next_p = p;
    byte_w = {f.sh, bus.mosi};
    next_f.bitn = f.bitn + 3'h1;
    next_f.sh = byte_w[6:0];
    if (f.bitn == 3'h7) begin
      next_f.val = ~f.val;
      next_p.tog = ~p.tog;
      next_p.data = byte_w;
      next_p.cfg = cfg_sel;
      next_p.val = f.val;
      next_p.rd = f.rd;
      if (!f.val) begin
        next_f.rd = byte_w[ADDR_RD_BIT];
        next_f.addr = byte_w[2:0];
      end
    end
  end

  always_ff @(posedge bus.sck or negedge frame_rstn) begin
    if (!frame_rstn) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  always_ff @(posedge bus.sck or negedge i_rstn) begin
    if (!i_rstn) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  // Output bit index and byte phase advance on the falling edge, so a
  // read value stands through its last bit after the rise that ends it
  always_ff @(negedge bus.sck or negedge frame_rstn) begin
    if (!frame_rstn) begin
      ncnt <= 3'h0;
      ophase <= 1'b0;
    end else begin
      ncnt <= ncnt + 3'h1;
      if (ncnt == 3'h7) begin
        ophase <= ~ophase;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core side, clocked by the system clock
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [NREG-1:0][7:0] stg;
    logic [NREG-1:0] stg_m;
    logic [2:0] tog_s;
    logic [2:0] cs_s;
    logic [2:0] qs_s;
    logic [1:0] dat_s;
    logic [2:0] addr;
    logic wr;
    logic rdq;
    logic [7:0] wbyte;
    logic [QMAX-1:0][7:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ovr;
    logic ne;
    dsf_ser_t st;
    logic [7:0] pre;
    logic [7:0] sh;
    logic [7:0] sum;
    logic [2:0] bitn;
    logic [2:0] nb;
    logic [AW:0] plen;
    logic mod_bit;
    logic data_out;
    logic data_oe;
    logic irq0;
    logic irq0_oe;
    logic irq1;
    logic irq1_oe;
    logic pll;
    logic pll_oe;
    logic clkout;
    logic clkout_oe;
  } dsf_core_t;

  dsf_core_t c, next_c;
  dsf_chip_t chip;
  logic [1:0] path;
  logic cont;
  logic pkt;
  logic full;
  logic [AW:0] cap;
  logic [7:0] head;

  assign chip = c.regs[REG_MODE][MODE_CHIP_LSB +: 3];
  assign path = c.regs[REG_MODE][MODE_PATH_LSB +: 2];
  assign cont = path == PATH_CONT;
  assign pkt = path[1];
  assign cap = (AW+1)'({c.regs[REG_MODE][MODE_DEPTH_LSB +: 2], 4'h0})
    + (AW+1)'(DEPTH_STEP);
  assign full = c.cnt >= cap;
  assign head = c.mem[c.rp];

  // Committed registers and, outside transmit state, the queue head only move
  // at deselect or while the queue is empty, so the link side reads them as static.
  always_comb begin
    rd_word = 8'h00;
    if (cfg_sel) begin
      if (ophase && f.rd) begin
        if (f.addr == REG_STAT) begin
          rd_word[STAT_NE_BIT] = c.ne;
          rd_word[STAT_FULL_BIT] = full;
          rd_word[STAT_OVR_BIT] = c.ovr;
        end else if (f.addr < 3'(NREG)) begin
          rd_word = c.regs[f.addr];
        end
      end
    end else if (!cont && c.cnt != '0) begin
      rd_word = head;
    end
  end

  assign bus.miso = rd_word[3'h7 - ncnt];
  assign bus.miso_oe = ~sel_none;

  always_comb begin
    logic push;
    logic pop;
    logic clr;
    logic tick;
    logic [7:0] pdata;
    logic [7:0] w;
    push = 1'b0;
    pop = 1'b0;
    clr = 1'b0;
    pdata = 8'h00;
    tick = 1'b0;
    w = {c.sh[6:0], i_demod_bit};
    next_c = c;
    next_c.tog_s = {c.tog_s[1:0], p.tog};
    next_c.cs_s = {c.cs_s[1:0], bus.cfg_port_select_n};
    next_c.qs_s = {c.qs_s[1:0], bus.queue_port_select_n};
    next_c.dat_s = {c.dat_s[0], bus.data_host};
    // Completed link byte
    if (c.tog_s[2] != c.tog_s[1]) begin
      if (p.cfg) begin
        if (!p.val) begin
          next_c.addr = p.data[2:0];
        end else if (!p.rd && c.addr < 3'(NREG)) begin
          next_c.stg[c.addr] = p.data;
          next_c.stg_m[c.addr] = 1'b1;
        end
      end else if (!cont) begin
        if (chip == CHIP_RX) begin
          next_c.rdq = 1'b1;
        end else begin
          next_c.wr = 1'b1;
          next_c.wbyte = p.data;
        end
      end
    end
    // Config deselect: staged values other than status land together; a staged status write with the overrun bit set clears the queue
    if (!c.cs_s[2] && c.cs_s[1]) begin
      for (int i = 0; i < NREG; i++) begin
        if (c.stg_m[i] && i != int'(REG_STAT)) begin
          next_c.regs[i] = c.stg[i];
        end
      end
      clr = c.stg_m[REG_STAT] && c.stg[REG_STAT][STAT_OVR_BIT];
      next_c.stg_m = '0;
    end
    // Queue deselect
    if (!c.qs_s[2] && c.qs_s[1]) begin
      next_c.wr = 1'b0;
      next_c.rdq = 1'b0;
      push = c.wr;
      pdata = c.wbyte;
      pop = c.rdq && c.cnt != '0;
    end
    // ----------------------------------------------------------------
    // Serializer
    // ----------------------------------------------------------------
    tick = c.pre == c.regs[REG_RATE];
    next_c.pre = tick ? 8'h00 : c.pre + 8'h01;
    if (chip == CHIP_TX && !cont) begin
      if (tick && c.st == SER_IDLE) begin
        next_c.bitn = 3'h0;
        next_c.plen = '0;
        next_c.sum = 8'h00;
        if (c.cnt != '0 && pkt) begin
          next_c.st = SER_PRE;
          next_c.sh = PREAMBLE_BYTE;
          next_c.nb = PREAMBLE_LEN - 3'h1;
        end else if (c.cnt != '0) begin
          next_c.st = SER_DATA;
          next_c.sh = head;
          pop = 1'b1;
        end
      end else if (tick) begin
        next_c.mod_bit = c.sh[7];
        next_c.sh = {c.sh[6:0], 1'b0};
        next_c.bitn = c.bitn + 3'h1;
        if (c.bitn == 3'h7) begin
          if (c.st == SER_PRE && c.nb != 3'h0) begin
            next_c.nb = c.nb - 3'h1;
            next_c.sh = PREAMBLE_BYTE;
          end else if (c.st == SER_PRE) begin
            next_c.st = SER_SYNC;
            next_c.sh = c.regs[REG_SYNC];
          end else if (c.st != SER_SUM && c.cnt != '0 &&
                       (!pkt || c.plen < (AW+1)'(QUEUE_MAX))) begin
            next_c.st = SER_DATA;
            next_c.sh = (pkt && c.regs[REG_PKT][PKT_WHITE_BIT]) ?
              head ^ WHITEN_KEY : head;
            pop = 1'b1;
            next_c.sum = c.sum ^ head;
            next_c.plen = c.plen + (AW+1)'(1);
          end else if (pkt && c.regs[REG_PKT][PKT_CRC_BIT] &&
                       c.st == SER_DATA) begin
            next_c.st = SER_SUM;
            next_c.sh = c.sum;
          end else begin
            next_c.st = SER_IDLE;
          end
        end
      end
    end else if (chip == CHIP_RX && !cont) begin
      if (tick) begin
        next_c.sh = w;
        next_c.bitn = c.bitn + 3'h1;
        if (!pkt) begin
          push = c.bitn == 3'h7;
          pdata = w;
        end else if (c.st != SER_DATA) begin
          next_c.st = SER_HUNT;
          if (w == c.regs[REG_SYNC]) begin
            next_c.st = SER_DATA;
            next_c.bitn = 3'h0;
            next_c.plen = '0;
          end
        end else if (c.bitn == 3'h7) begin
          push = 1'b1;
          pdata = c.regs[REG_PKT][PKT_WHITE_BIT] ? w ^ WHITEN_KEY : w;
          next_c.plen = c.plen + (AW+1)'(1);
          if (c.plen == (AW+1)'(QUEUE_MAX - 1)) begin
            next_c.st = SER_HUNT;
          end
        end
      end
    end else begin
      next_c.st = SER_IDLE;
      next_c.bitn = 3'h0;
      if (chip == CHIP_TX) begin
        next_c.mod_bit = c.dat_s[1];
      end
    end
    // ----------------------------------------------------------------
    // Queue update; a clear is applied first so a same-cycle push
    // lands in the emptied queue
    // ----------------------------------------------------------------
    if (clr) begin
      next_c.wp = '0;
      next_c.rp = '0;
      next_c.cnt = '0;
      next_c.ovr = 1'b0;
    end else if (pop) begin
      next_c.rp = c.rp + AW'(1);
      next_c.cnt = c.cnt - (AW+1)'(1);
    end
    if (push) begin
      if (next_c.cnt >= cap) begin
        next_c.ovr = 1'b1;
      end else begin
        next_c.mem[next_c.wp] = pdata;
        next_c.wp = next_c.wp + AW'(1);
        next_c.cnt = next_c.cnt + (AW+1)'(1);
      end
    end
    if (c.qs_s[1]) begin
      next_c.ne = c.cnt != '0;
    end
    // ----------------------------------------------------------------
    // Pin drive per chip state
    // ----------------------------------------------------------------
    next_c.data_oe = chip == CHIP_RX;
    next_c.data_out = cont ? i_demod_bit : 1'b0;
    next_c.irq0_oe = chip != CHIP_SLEEP &&
      !((chip == CHIP_STBY || chip == CHIP_FS) && cont);
    next_c.irq1_oe = next_c.irq0_oe;
    next_c.irq0 = cont ? 1'b0 : c.ne;
    next_c.irq1 = cont ? tick : full;
    next_c.pll_oe = chip != CHIP_SLEEP &&
      c.regs[REG_MODE][MODE_PLL_EN_BIT];
    next_c.pll = i_pll_locked;
    next_c.clkout_oe = chip != CHIP_SLEEP;
    next_c.clkout = ~c.clkout;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      c <= '0;
      c.regs[REG_MODE] <= MODE_RST;
      c.regs[REG_RATE] <= RATE_RST;
      c.regs[REG_SYNC] <= SYNC_RST;
      c.regs[REG_PKT] <= PKT_RST;
      c.cs_s <= 3'h7;
      c.qs_s <= 3'h7;
      c.irq0_oe <= 1'b1;
      c.irq1_oe <= 1'b1;
      c.clkout_oe <= 1'b1;
    end else begin
      c <= next_c;
    end
  end

  assign o_mod_bit = c.mod_bit;
  assign o_chip_state = chip;
  assign bus.data_dev = c.data_out;
  assign bus.data_dev_oe = c.data_oe;
  assign bus.irq0 = c.irq0;
  assign bus.irq0_oe = c.irq0_oe;
  assign bus.irq1 = c.irq1;
  assign bus.irq1_oe = c.irq1_oe;
  assign bus.pll_lock = c.pll;
  assign bus.pll_lock_oe = c.pll_oe;
  assign bus.clkout = c.clkout;
  assign bus.clkout_oe = c.clkout_oe;
endmodule

// File: design/dsf_pkg.sv
// Shared constants and types of the dual-select SPI queue port.
// Assumes both ends and the bench import it; no logic inside.
package dsf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int NREG = 5;
  localparam logic [2:0] REG_MODE = 3'h0;
  localparam logic [2:0] REG_RATE = 3'h1;
  localparam logic [2:0] REG_SYNC = 3'h2;
  localparam logic [2:0] REG_PKT = 3'h3;
  localparam logic [2:0] REG_STAT = 3'h4;
  localparam int MODE_CHIP_LSB = 5;
  localparam int MODE_PATH_LSB = 3;
  localparam int MODE_DEPTH_LSB = 1;
  localparam int MODE_PLL_EN_BIT = 0;
  localparam int PKT_CRC_BIT = 0;
  localparam int PKT_WHITE_BIT = 1;
  localparam int STAT_OVR_BIT = 0;
  localparam int STAT_FULL_BIT = 6;
  localparam int STAT_NE_BIT = 7;
  localparam int ADDR_RD_BIT = 7;
  localparam logic [7:0] MODE_RST = 8'h20;
  localparam logic [7:0] RATE_RST = 8'h09;
  localparam logic [7:0] SYNC_RST = 8'h2D;
  localparam logic [7:0] PKT_RST = 8'h00;
  // ----------------------------------------------------------------
  // Modes and codes
  // ----------------------------------------------------------------
  typedef logic [2:0] dsf_chip_t;
  localparam dsf_chip_t CHIP_SLEEP = 3'h0;
  localparam dsf_chip_t CHIP_STBY = 3'h1;
  localparam dsf_chip_t CHIP_FS = 3'h2;
  localparam dsf_chip_t CHIP_RX = 3'h3;
  localparam dsf_chip_t CHIP_TX = 3'h4;
  localparam logic [1:0] PATH_CONT = 2'h0;
  localparam logic [1:0] PATH_BUF = 2'h1;
  localparam int QUEUE_MAX = 64;
  localparam int DEPTH_STEP = 16;
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [2:0] PREAMBLE_LEN = 3'h3;
  localparam logic [7:0] WHITEN_KEY = 8'hFF;
  localparam int SCK_HALF = 4;
  typedef enum logic [2:0] {
    SER_IDLE, SER_PRE, SER_SYNC, SER_DATA, SER_SUM, SER_HUNT
  } dsf_ser_t;
  typedef logic [1:0] dsf_op_t;
  localparam dsf_op_t OP_CFG_WR = 2'h0;
  localparam dsf_op_t OP_CFG_RD = 2'h1;
  localparam dsf_op_t OP_Q_WR = 2'h2;
  localparam dsf_op_t OP_Q_RD = 2'h3;
endpackage

// File: design/dsf_if.sv
// Pins between the host master and the transceiver data port.
// Assumes the bench resolves each shared wire from its enables.
`timescale 1ns/1ps
interface dsf_if;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic cfg_port_select_n;
  logic queue_port_select_n;
  logic data_dev;
  logic data_dev_oe;
  logic data_host;
  logic data_host_oe;
  logic irq0;
  logic irq0_oe;
  logic irq1;
  logic irq1_oe;
  logic pll_lock;
  logic pll_lock_oe;
  logic clkout;
  logic clkout_oe;
  modport dev(
    input sck, mosi, cfg_port_select_n, queue_port_select_n, data_host,
    output miso, miso_oe, data_dev, data_dev_oe, irq0, irq0_oe, irq1,
    output irq1_oe, pll_lock, pll_lock_oe, clkout, clkout_oe
  );
  modport host(
    output sck, mosi, cfg_port_select_n, queue_port_select_n, data_host,
    output data_host_oe,
    input miso, data_dev
  );
endinterface

// File: design/dsf_host_end.sv
// Host master end: one register or one queue byte per request.
// Assumes the device end on the bus pins; makes the serial clock.
`timescale 1ns/1ps
module dsf_host_end #(
  parameter int HALF = dsf_pkg::SCK_HALF
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input dsf_pkg::dsf_op_t i_op,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_data_bit,
  input wire logic i_data_drive,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic o_data_bit,
  dsf_if.host bus
);
  import dsf_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END, H_GAP
  } dsf_hst_t;
  typedef struct packed {
    dsf_hst_t st;
    logic [7:0] tmr;
    logic [4:0] nbits;
    logic [15:0] out;
    logic [7:0] in;
    logic sck;
    logic mosi;
    logic cs_n;
    logic qs_n;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic [1:0] miso_s;
    logic [1:0] dat_s;
    logic dout;
    logic doe;
  } dsf_host_t;

  dsf_host_t h, next_h;
  logic tdone;

  assign tdone = h.tmr == 8'(HALF - 1);

  always_comb begin
    next_h = h;
    next_h.done = 1'b0;
    next_h.miso_s = {h.miso_s[0], bus.miso};
    next_h.dat_s = {h.dat_s[0], bus.data_dev};
    next_h.dout = i_data_bit;
    next_h.doe = i_data_drive;
    next_h.tmr = (tdone || h.st == H_IDLE) ? 8'h00 : h.tmr + 8'h01;
    unique case (h.st)
      H_IDLE: begin
        if (i_req) begin
          next_h.busy = 1'b1;
          next_h.st = H_SETUP;
          if (!i_op[1]) begin
            next_h.cs_n = 1'b0;
            next_h.out = {i_op[0], i_addr, i_wdata};
            next_h.nbits = 5'h10;
          end else begin
            next_h.qs_n = 1'b0;
            next_h.out = {i_wdata, 8'h00};
            next_h.nbits = 5'h08;
          end
        end
      end
      H_SETUP: begin
        if (tdone) begin
          next_h.mosi = h.out[15];
          next_h.st = H_LOW;
        end
      end
      H_LOW: begin
        if (tdone) begin
          next_h.sck = 1'b1;
          next_h.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tdone) begin
          next_h.sck = 1'b0;
          next_h.in = {h.in[6:0], h.miso_s[1]};
          next_h.out = {h.out[14:0], 1'b0};
          next_h.mosi = h.out[14];
          next_h.nbits = h.nbits - 5'h01;
          next_h.st = (h.nbits == 5'h01) ? H_END : H_LOW;
        end
      end
      H_END: begin
        if (tdone) begin
          next_h.cs_n = 1'b1;
          next_h.qs_n = 1'b1;
          next_h.st = H_GAP;
        end
      end
      H_GAP: begin
        // Hold deselect long enough for the device core to see it
        if (tdone) begin
          next_h.busy = 1'b0;
          next_h.done = 1'b1;
          next_h.rdata = h.in;
          next_h.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      h <= '0;
      h.cs_n <= 1'b1;
      h.qs_n <= 1'b1;
    end else begin
      h <= next_h;
    end
  end

  assign o_busy = h.busy;
  assign o_done = h.done;
  assign o_rdata = h.rdata;
  assign o_data_bit = h.dat_s[1];
  assign bus.sck = h.sck;
  assign bus.mosi = h.mosi;
  assign bus.cfg_port_select_n = h.cs_n;
  assign bus.queue_port_select_n = h.qs_n;
  assign bus.data_host = h.dout;
  assign bus.data_host_oe = h.doe;
endmodule

// File: dv/dsf_properties.sv
// Checker of the pins joining the host and device ends.
// Assumes the testbench wires it to the interface by name.
`timescale 1ns/1ps
module dsf_properties (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic cfg_port_select_n,
  input wire logic queue_port_select_n,
  input wire logic data_dev_oe,
  input wire logic irq0_oe,
  input wire logic irq1_oe,
  input wire logic pll_lock_oe,
  input wire logic clkout_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ------------------------------------------------------------------
  // Clock rises per select, cleared while nothing is selected
  // ------------------------------------------------------------------
  logic sck_q;
  logic [5:0] nrise;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_q <= 1'b0;
      nrise <= 6'h00;
    end else begin
      sck_q <= sck;
      if (cfg_port_select_n && queue_port_select_n) begin
        nrise <= 6'h00;
      end else if (sck && !sck_q) begin
        nrise <= nrise + 6'h01;
      end
    end
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  a_miso_drive: assert property (miso_oe ==
    (!cfg_port_select_n || !queue_port_select_n))
    else $error("miso enable disagrees with selects");
  a_one_select: assert property (!(!cfg_port_select_n &&
    !queue_port_select_n)) else $error("both selects low");
  a_queue_bits: assert property ($rose(queue_port_select_n) |->
    nrise == 6'h08) else $error("queue frame not 8 bits");
  a_cfg_bits: assert property ($rose(cfg_port_select_n) |->
    nrise == 6'h10) else $error("config frame not 16 bits");
  a_mosi_hold: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while clock high");
  a_sck_idle: assert property (cfg_port_select_n &&
    queue_port_select_n |-> !sck) else $error("clock runs unselected");
  a_irq_pair: assert property (irq0_oe == irq1_oe)
    else $error("interrupt enables differ");
  a_data_awake: assert property (data_dev_oe |-> clkout_oe)
    else $error("data driven while asleep");
  a_pll_awake: assert property (pll_lock_oe |-> clkout_oe)
    else $error("lock driven while asleep");
  cover property ($rose(queue_port_select_n));
  cover property ($rose(cfg_port_select_n));
  cover property (data_dev_oe);
  cover property (pll_lock_oe && irq0_oe);
endmodule

// File: dv/testbench.sv
// Bench joining host and device ends, compared with a small model.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/1ps
module testbench;
  import dsf_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b1;
  logic req = 1'b0;
  dsf_op_t op = OP_CFG_WR;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic dbit = 1'b0;
  logic ddrv = 1'b0;
  logic demod = 1'b0;
  logic locked = 1'b0;
  logic busy;
  logic done;
  logic mod_bit;
  logic host_bit;
  logic [7:0] rdata;
  dsf_chip_t chip;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] rs = 32'h0000DB05;
  logic [7:0] q_mode;
  int q_cnt;
  logic q_ovr;
  logic [7:0] q_data [$];
  dsf_if bus ();
  dsf_dev_end dsf_dev_end_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_demod_bit(demod), .i_pll_locked(locked), .o_mod_bit(mod_bit),
    .o_chip_state(chip), .bus(bus));
  dsf_host_end dsf_host_end_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_req(req), .i_op(op), .i_addr(addr), .i_wdata(wdata),
    .i_data_bit(dbit), .i_data_drive(ddrv), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_data_bit(host_bit), .bus(bus));
  dsf_properties dsf_properties_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .sck(bus.sck), .mosi(bus.mosi), .miso_oe(bus.miso_oe),
    .cfg_port_select_n(bus.cfg_port_select_n),
    .queue_port_select_n(bus.queue_port_select_n),
    .data_dev_oe(bus.data_dev_oe), .irq0_oe(bus.irq0_oe),
    .irq1_oe(bus.irq1_oe), .pll_lock_oe(bus.pll_lock_oe),
    .clkout_oe(bus.clkout_oe));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [7:0] stat_exp();
    return {q_cnt != 0, q_cnt == DEPTH_STEP * (q_mode[2:1] + 1), 5'h00,
      q_ovr};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t bit %b want %b", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Request is held over the taking edge only; busy refuses the rest
  task automatic xfer(input dsf_op_t o, input logic [6:0] a,
    input logic [7:0] d);
    int k;
    @(posedge i_clk);
    #1;
    req = 1'b1;
    op = o;
    addr = a;
    wdata = d;
    @(posedge i_clk);
    #1;
    req = 1'b0;
    for (k = 0; k < 400 && done !== 1'b1; k++) begin
      @(posedge i_clk);
      #1;
    end
    if (k == 400) begin
      n_fail++;
      $display("ERROR %0t no done", $time);
    end
  endtask
  // Waits past the commit at deselect before anything is looked at
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    xfer(OP_CFG_WR, {4'h0, a}, d);
    if (a == REG_MODE) begin
      q_mode = d;
    end
    if (a == REG_STAT && d[STAT_OVR_BIT]) begin
      q_cnt = 0;
      q_ovr = 1'b0;
      q_data.delete();
    end
    repeat (6) @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    xfer(OP_CFG_RD, {4'h0, a}, 8'h00);
  endtask
  task automatic push(input logic [7:0] d);
    xfer(OP_Q_WR, 7'h00, d);
    if (q_mode[4:3] != PATH_CONT) begin
      if (q_cnt < DEPTH_STEP * (q_mode[2:1] + 1)) begin
        q_cnt++;
        q_data.push_back(d);
      end else begin
        q_ovr = 1'b1;
      end
    end
  endtask
  // Queue read in receive state: one byte per select, oldest first
  task automatic qrd();
    xfer(OP_Q_RD, 7'h00, 8'h00);
    chk8(rdata, q_data.pop_front());
    q_cnt--;
  endtask
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int c;
    int p;
    int d;
    int n;
    logic [7:0] m;
    logic [7:0] rst_v [4];
    rst_v = '{MODE_RST, RATE_RST, SYNC_RST, PKT_RST};
    q_mode = MODE_RST;
    q_cnt = 0;
    q_ovr = 1'b0;
    // A real falling edge, so link-side flops with no clock in reset clear
    #1;
    i_rstn = 1'b0;
    repeat (16) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    for (n = 0; n < 8; n++) begin
      rd(n[2:0]);
      chk8(rdata, n < 4 ? rst_v[n] : 8'h00);
    end
    m = rs[7:0];
    rs = xs(rs);
    wr(REG_SYNC, m);
    rd(REG_SYNC);
    chk8(rdata, m);
    for (c = 0; c < 5; c++) begin
      for (p = 0; p < 4; p++) begin
        locked = rs[0];
        rs = xs(rs);
        m = {c[2:0], p[1:0], 2'h0, 1'b1};
        wr(REG_MODE, m);
        chk8({5'h00, chip}, {5'h00, m[7:5]});
        chk1(bus.clkout_oe, c != 0);
        chk1(bus.data_dev_oe, c == 3);
        chk1(bus.irq0_oe, c != 0 && (c > 2 || p != 0));
        chk1(bus.pll_lock_oe, c != 0);
        chk1(bus.pll_lock, locked);
      end
    end
    for (d = 0; d < 4; d++) begin
      wr(REG_MODE, {CHIP_STBY, PATH_BUF, d[1:0], 1'b0});
      wr(REG_STAT, 8'h01);
      for (n = 0; n <= DEPTH_STEP * (d + 1); n++) begin
        push(rs[7:0]);
        rs = xs(rs);
        if (n == 0 || n >= DEPTH_STEP * (d + 1) - 1) begin
          rd(REG_STAT);
          chk8(rdata, stat_exp());
          chk1(bus.irq0, q_cnt != 0);
          chk1(bus.irq1, q_cnt == DEPTH_STEP * (d + 1));
        end
      end
    end
    wr(REG_STAT, 8'h01);
    // Slow bit rate keeps the receive serializer from pushing meanwhile
    wr(REG_RATE, 8'hFF);
    for (n = 0; n < 2; n++) begin
      push(rs[7:0]);
      rs = xs(rs);
    end
    wr(REG_MODE, {CHIP_RX, PATH_BUF, 3'h0});
    qrd();
    qrd();
    rd(REG_STAT);
    chk8(rdata, stat_exp());
    wr(REG_MODE, {CHIP_STBY, PATH_CONT, 3'h0});
    push(8'hA5);
    rd(REG_STAT);
    chk8(rdata, stat_exp());
    wr(REG_RATE, 8'h03);
    for (n = 0; n < 16; n++) begin
      if (n == 0) begin
        wr(REG_MODE, {CHIP_TX, PATH_CONT, 3'h0});
      end
      if (n == 8) begin
        wr(REG_MODE, {CHIP_RX, PATH_CONT, 3'h0});
      end
      ddrv = n < 8;
      dbit = rs[0];
      demod = rs[1];
      rs = xs(rs);
      repeat (20) @(posedge i_clk);
      #1;
      if (n < 8) begin
        chk1(mod_bit, dbit);
      end else begin
        chk1(host_bit, demod);
      end
    end
    end_sim();
  end
  initial begin
    #600000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end
endmodule
